// ==== verilog/est_shutoff.sv ====
`timescale 1ns/1ns
// Overview of operation
// (R1) Enabled stop input halts switching, no software
// (R2) Enabled: terminals one, three reserved exclusively
// (R3) Terminal one fixed reset function, make contact
// (R4) Terminal three fixed stop function, break
// (R5) Stop input latches trip, reports code
// (R6) Open or mismatched stop terminal also trips
// (R7) Only terminal-one reset clears; console ignored
// (R8) Installer sets switch on; default off
// (R9) Switch off: terminals freely settable, defaults
// (R10) Reset function forces make-contact polarity
// (R11) Stop code on three forces break polarity
// (R12) Switch on moves reset function to one
// (R13) Switch off never restores removed reset
// (R14) Stop code not selectable from console
// (R15) After on-off: one keeps reset, three none
// (R16) Power off before moving the switch
// (R17) Allocation applied before functions evaluated
module est_shutoff (
	input  wire logic                  clock_in,        // 50 MHz clock
	input  wire logic                  srst_in,         // Sync reset, high
	input  wire logic                  shutoff_enable_switch_in, // Board switch
	input  wire logic                  input_terminal_one_in,    // Raw terminal one
	input  wire logic                  input_terminal_two_in,    // Raw terminal two
	input  wire logic                  input_terminal_three_in,  // Raw terminal three
	input  wire est_pkg::est_cfg_wr_t  cfg_wr_in,       // Console setting write
	input  wire logic                  console_reset_in, // Console reset pulse
	input  wire logic                  gate_request_in, // Software gate enable
	output logic                       gate_enable_out, // Power stage switching allowed
	output logic                       trip_out,        // Shutoff trip latched
	output logic [7:0]                 shutoff_trip_code_out, // Trip code
	output est_pkg::est_term_cfg_t     term_one_cfg_out,   // Terminal one setting
	output est_pkg::est_term_cfg_t     term_two_cfg_out,   // Terminal two setting
	output est_pkg::est_term_cfg_t     term_three_cfg_out, // Terminal three setting
	output logic                       reset_active_out,   // Reset function asserted
	output logic                       ext_trip_out,       // External trip function asserted
	output logic                       rev_run_out         // Reverse run function asserted
);

	logic [2:0]             pins_sync;
	logic                   en_sync;
	logic                   en_prev_ff;
	logic                   en_seen_ff;
	est_pkg::est_term_cfg_t cfg_ff [3];
	est_pkg::est_term_cfg_t nxt_cfg [3];
	logic [2:0]             active;
	logic                   stop_req;
	logic                   reset_req;
	logic                   trip_ff;
	logic                   gate_ff;
	logic [7:0]             code_ff;
	logic                   reset_ff;
	logic                   ext_ff;
	logic                   rev_ff;

	// Switch and pins are asynchronous to the clock
	est_sync #(
		.WIDTH (4)
	) u_sync (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.async_in ({shutoff_enable_switch_in, input_terminal_three_in,
			input_terminal_two_in, input_terminal_one_in}),
		.sync_out ({en_sync, pins_sync})
	);

	// Polarity forcing applied to every setting write
	function automatic est_pkg::est_term_cfg_t force_pol(
		input est_pkg::est_term_cfg_t c,
		input logic                   is_three
	);
		est_pkg::est_term_cfg_t r;
		r = c;
		if (c.func == est_pkg::FUNC_RESET) begin
			r.pol = est_pkg::POL_MAKE; // R10
		end else if (is_three && c.func == est_pkg::FUNC_EMSTOP) begin
			r.pol = est_pkg::POL_BREAK; // R11
		end
		return r;
	endfunction

	// Function is active when level differs from polarity (break = open asserts)
	function automatic logic term_active(
		input logic                   lvl,
		input est_pkg::est_term_cfg_t c
	);
		return (c.pol == est_pkg::POL_BREAK) ? ~lvl : lvl;
	endfunction

	// Switch edge tracking; en_seen marks that enable was ever on
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			en_prev_ff <= 1'b0;
			en_seen_ff <= 1'b0;
		end else begin
			en_prev_ff <= en_sync;
			if (en_sync) begin
				en_seen_ff <= 1'b1;
			end
		end
	end

	// Next terminal settings: console write, then forced allocation on top
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			nxt_cfg[i] = cfg_ff[i];
		end
		// Console writes; stop code refused from console
		if (cfg_wr_in.valid && cfg_wr_in.term != 2'h3
				&& cfg_wr_in.cfg.func != est_pkg::FUNC_EMSTOP) begin // R14 R9
			nxt_cfg[cfg_wr_in.term] = force_pol(cfg_wr_in.cfg,
				cfg_wr_in.term == est_pkg::TERM_THREE);
		end
		// Polarity pins for three remain fixed at break while it holds stop code
		if (!en_sync && en_prev_ff) begin
			// Switch turned off: three loses its function, keeps polarity
			nxt_cfg[est_pkg::TERM_THREE].func = est_pkg::FUNC_NONE; // R15
			nxt_cfg[est_pkg::TERM_THREE].pol  = est_pkg::POL_BREAK; // R15
			nxt_cfg[est_pkg::TERM_ONE].func   = est_pkg::FUNC_RESET; // R15
			nxt_cfg[est_pkg::TERM_ONE].pol    = est_pkg::POL_MAKE;
		end
		if (en_sync) begin
			// Reserved terminals overwrite anything written
			nxt_cfg[est_pkg::TERM_ONE].func   = est_pkg::FUNC_RESET; // R2 R3
			nxt_cfg[est_pkg::TERM_ONE].pol    = est_pkg::POL_MAKE;   // R3
			nxt_cfg[est_pkg::TERM_THREE].func = est_pkg::FUNC_EMSTOP; // R2 R4
			nxt_cfg[est_pkg::TERM_THREE].pol  = est_pkg::POL_BREAK;  // R4
			// Duplicate reset allocation elsewhere removed
			if (nxt_cfg[est_pkg::TERM_TWO].func == est_pkg::FUNC_RESET) begin
				nxt_cfg[est_pkg::TERM_TWO].func = est_pkg::FUNC_NONE; // R12
			end
		end
	end

	// Settings store; a removed allocation returns only through a console write
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cfg_ff[0] <= '{func: est_pkg::RST_T1_FUNC, pol: est_pkg::RST_T1_POL}; // R9
			cfg_ff[1] <= '{func: est_pkg::RST_T2_FUNC, pol: est_pkg::RST_T2_POL};
			cfg_ff[2] <= '{func: est_pkg::RST_T3_FUNC, pol: est_pkg::RST_T3_POL}; // R9
		end else begin
			for (int i = 0; i < 3; i++) begin
				cfg_ff[i] <= nxt_cfg[i]; // R13
			end
		end
	end

	// Function evaluation uses the forced allocation whenever enabled
	generate
		for (genvar g = 0; g < 3; g++) begin : g_act
			assign active[g] = term_active(pins_sync[g],
				en_sync ? nxt_cfg[g] : cfg_ff[g]); // R17
		end
	endgenerate

	// Stop asserted when terminal three open or wrong level while enabled
	assign stop_req  = en_sync && active[est_pkg::TERM_THREE]; // R5 R6
	assign reset_req = en_sync && pins_sync[est_pkg::TERM_ONE]; // R7

	// Trip latch: only terminal-one reset clears, stop wins over clear
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			trip_ff <= 1'b0;
			code_ff <= est_pkg::TRIP_CODE_NONE;
		end else if (stop_req) begin
			trip_ff <= 1'b1; // R5
			code_ff <= est_pkg::TRIP_CODE_SHUTOFF; // R5
		end else if (reset_req) begin
			trip_ff <= 1'b0; // R7
			code_ff <= est_pkg::TRIP_CODE_NONE;
		end
	end

	// Hardware gate path; software request cannot override a stop
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			gate_ff <= 1'b0;
		end else begin
			gate_ff <= gate_request_in && !stop_req && !trip_ff; // R1
		end
	end

	// Decoded terminal functions (reserved terminals excluded while enabled, except for the reset function)
	function automatic logic func_hit(
		input logic [2:0]        act,
		input logic [7:0]        code,
		input logic              en
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (act[i] && cfg_ff[i].func == code
					&& !(en && i != int'(est_pkg::TERM_TWO) && code != est_pkg::FUNC_RESET)) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// Registered function outputs; console reset deliberately unused for trip
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			reset_ff <= 1'b0;
			ext_ff   <= 1'b0;
			rev_ff   <= 1'b0;
		end else begin
			reset_ff <= func_hit(active, est_pkg::FUNC_RESET, en_sync) || console_reset_in;
			ext_ff   <= func_hit(active, est_pkg::FUNC_EXT_TRIP, en_sync); // R2
			rev_ff   <= func_hit(active, est_pkg::FUNC_REV_RUN, en_sync);  // R2
		end
	end

	assign gate_enable_out       = gate_ff;
	assign trip_out              = trip_ff;
	assign shutoff_trip_code_out = code_ff;
	assign term_one_cfg_out      = cfg_ff[0];
	assign term_two_cfg_out      = cfg_ff[1];
	assign term_three_cfg_out    = cfg_ff[2];
	assign reset_active_out      = reset_ff;
	assign ext_trip_out          = ext_ff;
	assign rev_run_out           = rev_ff;

	// Stop request leads to trip and gate off next cycle
	property p_stop_trips;
		@(posedge clock_in) disable iff (srst_in)
		stop_req |=> trip_out && !gate_enable_out && shutoff_trip_code_out == 8'h25;
	endproperty
	a_stop_trips: assert property (p_stop_trips) else $error("stop did not trip"); // R5

	property p_gate_off;
		@(posedge clock_in) disable iff (srst_in)
		trip_out |-> !gate_enable_out;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("gate on while tripped"); // R1

	sequence s_tripped_no_reset;
		trip_out && !reset_req && !stop_req;
	endsequence
	property p_trip_holds;
		@(posedge clock_in) disable iff (srst_in)
		s_tripped_no_reset |=> trip_out;
	endproperty
	a_trip_holds: assert property (p_trip_holds) else $error("trip cleared without reset"); // R7

	property p_enabled_alloc;
		@(posedge clock_in) disable iff (srst_in)
		en_sync |=> term_one_cfg_out.func == 8'h12 && term_one_cfg_out.pol == 2'h0
			&& term_three_cfg_out.func == 8'h40 && term_three_cfg_out.pol == 2'h1;
	endproperty
	a_enabled_alloc: assert property (p_enabled_alloc) else $error("reserved alloc wrong"); // R3

	property p_no_dup_reset;
		@(posedge clock_in) disable iff (srst_in)
		en_sync |=> term_two_cfg_out.func != 8'h12;
	endproperty
	a_no_dup_reset: assert property (p_no_dup_reset) else $error("duplicate reset"); // R12

	property p_reset_pol;
		@(posedge clock_in) disable iff (srst_in)
		term_two_cfg_out.func == 8'h12 |-> term_two_cfg_out.pol == 2'h0;
	endproperty
	a_reset_pol: assert property (p_reset_pol) else $error("reset polarity not make"); // R10

	property p_stop_pol;
		@(posedge clock_in) disable iff (srst_in)
		term_three_cfg_out.func == 8'h40 |-> term_three_cfg_out.pol == 2'h1;
	endproperty
	a_stop_pol: assert property (p_stop_pol) else $error("stop polarity not break"); // R11

	property p_off_after_on;
		@(posedge clock_in) disable iff (srst_in)
		(!en_sync && en_prev_ff && !cfg_wr_in.valid) |=>
			term_three_cfg_out.func == 8'hff && term_three_cfg_out.pol == 2'h1
			&& term_one_cfg_out.func == 8'h12;
	endproperty
	a_off_after_on: assert property (p_off_after_on) else $error("on-off alloc wrong"); // R15

	property p_no_console_stop;
		@(posedge clock_in) disable iff (srst_in)
		(!en_sync && !$past(en_sync) && term_three_cfg_out.func != 8'h40)
			|=> term_three_cfg_out.func != 8'h40;
	endproperty
	a_no_console_stop: assert property (p_no_console_stop) else $error("stop via console"); // R14

	// After an on-off cycle, terminal two regains reset only by a console write
	property p_no_restore;
		@(posedge clock_in) disable iff (srst_in)
		(en_seen_ff && !en_sync && term_two_cfg_out.func != est_pkg::FUNC_RESET
			&& !(cfg_wr_in.valid && cfg_wr_in.term == est_pkg::TERM_TWO))
			|=> term_two_cfg_out.func != est_pkg::FUNC_RESET;
	endproperty
	a_no_restore: assert property (p_no_restore) else $error("reset allocation restored"); // R13

	// Gate follows the software request when nothing stops it
	property p_gate_follows;
		@(posedge clock_in) disable iff (srst_in)
		(gate_request_in && !stop_req && !trip_out) |=> gate_enable_out;
	endproperty
	a_gate_follows: assert property (p_gate_follows) else $error("gate not granted"); // R1

	// Open loop or wrong level on terminal three while enabled trips next edge
	sequence s_stop_level;
		en_sync && !pins_sync[est_pkg::TERM_THREE];
	endsequence
	property p_open_trips;
		@(posedge clock_in) disable iff (srst_in)
		s_stop_level |=> trip_out;
	endproperty
	a_open_trips: assert property (p_open_trips) else $error("open loop did not trip"); // R6

endmodule // est_shutoff

// ==== verilog/est_pkg.sv ====
package est_pkg;

	// Terminal function codes (two-digit decimal codes held in 8 bits)
	localparam logic [7:0] FUNC_NONE      = 8'hff;
	localparam logic [7:0] FUNC_REV_RUN   = 8'h01;
	localparam logic [7:0] FUNC_EXT_TRIP  = 8'h0c;
	localparam logic [7:0] FUNC_RESET     = 8'h12;
	localparam logic [7:0] FUNC_EMSTOP    = 8'h40;

	// Polarity codes
	localparam logic [1:0] POL_MAKE       = 2'h0;
	localparam logic [1:0] POL_BREAK      = 2'h1;

	// Values after reset
	localparam logic [7:0] RST_T1_FUNC    = FUNC_REV_RUN;
	localparam logic [1:0] RST_T1_POL     = POL_MAKE;
	localparam logic [7:0] RST_T2_FUNC    = FUNC_NONE;
	localparam logic [1:0] RST_T2_POL     = POL_MAKE;
	localparam logic [7:0] RST_T3_FUNC    = FUNC_EXT_TRIP;
	localparam logic [1:0] RST_T3_POL     = POL_MAKE;

	// Trip code reported for the shutoff trip
	localparam logic [7:0] TRIP_CODE_SHUTOFF = 8'h25;
	localparam logic [7:0] TRIP_CODE_NONE    = 8'h00;

	// Synchroniser depth
	localparam int SYNC_STAGES = 2;

	// One terminal's setting
	typedef struct packed {
		logic [7:0] func;
		logic [1:0] pol;
	} est_term_cfg_t;

	// A console write request
	typedef struct packed {
		logic          valid;
		logic [1:0]    term;
		est_term_cfg_t cfg;
	} est_cfg_wr_t;

	typedef enum logic [1:0] {
		TERM_ONE   = 2'h0,
		TERM_TWO   = 2'h1,
		TERM_THREE = 2'h2
	} est_term_t;

endpackage

// ==== verilog/est_sync.sv ====
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous terminal levels
module est_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clock_in,  // System clock
	input  wire logic             srst_in,   // Sync reset
	input  wire logic [WIDTH-1:0] async_in,  // Raw pin levels
	output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// First stage feeds only the second
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule // est_sync

// ==== verification/est_contacts.sv ====
`timescale 1ns/1ns
// Safety contacts wired to terminals one and three
module est_contacts (
	input  wire logic clock_in,       // Bench clock
	input  wire logic stop_press_in,  // Stop button pressed
	input  wire logic wire_open_in,   // Stop loop cut
	input  wire logic reset_press_in, // Reset button pressed
	output logic      term_one_out,   // Terminal one level
	output logic      term_three_out  // Terminal three level
);
	// Break contact: a cut wire looks exactly like a press, which is the point
	always_ff @(posedge clock_in) begin
		term_three_out <= !(stop_press_in || wire_open_in);
		term_one_out   <= reset_press_in;
	end
endmodule // est_contacts

// ==== verification/est_shutoff_tb.sv ====
`timescale 1ns/1ns
module est_shutoff_tb;
	logic                   clock_in = 1'b0;
	logic                   srst_in  = 1'b1;
	logic                   sw, stop_p, open_w, rst_p, t1, t2, t3, con_rst, gate_req;
	logic                   gate, trip, external_trip_function, rev, rst_act;
	logic [7:0]             code;
	est_pkg::est_cfg_wr_t   wr;
	est_pkg::est_term_cfg_t cfg_seen [3];
	est_pkg::est_term_cfg_t exp_cfg  [3];
	integer                 seed = 32'hbb36f2a2;
	int                     err_total, tests_run, cyc;
	logic [1:0]             term;
	logic [7:0]             func;
	logic [1:0]             pol;

	always #10 clock_in = ~clock_in;

	est_contacts u_contacts (.clock_in(clock_in), .stop_press_in(stop_p), .wire_open_in(open_w),
		.reset_press_in(rst_p), .term_one_out(t1), .term_three_out(t3));

	est_shutoff dut (.clock_in(clock_in), .srst_in(srst_in), .shutoff_enable_switch_in(sw),
		.input_terminal_one_in(t1), .input_terminal_two_in(t2), .input_terminal_three_in(t3),
		.cfg_wr_in(wr), .console_reset_in(con_rst), .gate_request_in(gate_req),
		.gate_enable_out(gate), .trip_out(trip), .shutoff_trip_code_out(code),
		.term_one_cfg_out(cfg_seen[0]), .term_two_cfg_out(cfg_seen[1]),
		.term_three_cfg_out(cfg_seen[2]), .reset_active_out(rst_act),
		.ext_trip_out(external_trip_function), .rev_run_out(rev));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, far above the under two hundred cycles the sequence needs
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	// Compare all three terminal settings against the bench model
	task automatic chk_cfgs();
		for (int i = 0; i < 3; i++) begin
			chk($sformatf("term %0d cfg", i), 16'(exp_cfg[i]), 16'(cfg_seen[i]));
		end
	endtask

	// Console write, one cycle pulse, result visible one cycle on
	task automatic cw(input logic [1:0] tm, input logic [7:0] fn, input logic [1:0] pl);
		@(posedge clock_in);
		wr <= '{valid: 1'b1, term: tm, cfg: '{func: fn, pol: pl}};
		@(posedge clock_in);
		wr.valid <= 1'b0;
		wait_n(1);
	endtask

	// Expected setting after a console write with the switch off
	function automatic est_pkg::est_term_cfg_t exp_wr(input logic [7:0] fn, input logic [1:0] pl);
		exp_wr.func = fn;
		exp_wr.pol  = (fn == est_pkg::FUNC_RESET) ? est_pkg::POL_MAKE : pl;
	endfunction

	task automatic pulse_reset_pin();
		@(posedge clock_in);
		rst_p <= 1'b1;
		wait_n(4);
		chk("reset func", 1'b1, rst_act);
		@(posedge clock_in);
		rst_p <= 1'b0;
		wait_n(4);
	endtask

	initial begin
		{sw, stop_p, open_w, rst_p, t2, con_rst} = '0;
		gate_req = 1'b1;
		wr       = '0;
		repeat (20) @(posedge clock_in);
		srst_in <= 1'b0;
		wait_n(4);
		exp_cfg = '{'{8'h01, 2'h0}, '{8'hff, 2'h0}, '{8'h0c, 2'h0}};
		chk_cfgs();
		chk("trip", 1'b0, trip);
		chk("gate", 1'b1, gate);
		chk("ext trip", 1'b1, external_trip_function);
		@(posedge clock_in);
		rst_p    <= 1'b1;
		gate_req <= 1'b0;
		wait_n(5);
		chk("rev run", 1'b1, rev);
		chk("gate idle", 1'b0, gate);
		@(posedge clock_in);
		rst_p    <= 1'b0;
		gate_req <= 1'b1;
		// Random console writes, term 3 is a hole and must change nothing
		for (int n = 0; n < 16; n++) begin
			term = 2'($random(seed));
			func = 8'($random(seed));
			pol  = 2'($random(seed) & 1);
			if (func == est_pkg::FUNC_EMSTOP) begin
				func = 8'h41;
			end
			@(posedge clock_in);
			t2 <= 1'($random(seed));
			cw(term, func, pol);
			if (term != 2'h3) begin
				exp_cfg[term] = exp_wr(func, pol);
			end
			chk_cfgs();
		end
		cw(2'h1, est_pkg::FUNC_RESET, 2'h1);
		exp_cfg[1] = '{8'h12, 2'h0};
		chk_cfgs();
		cw(2'h2, est_pkg::FUNC_EMSTOP, 2'h0);
		chk_cfgs();
		// Installer throws the switch; power-off step not modelled here
		@(posedge clock_in);
		sw <= 1'b1;
		wait_n(5);
		exp_cfg = '{'{8'h12, 2'h0}, '{8'hff, exp_cfg[1].pol}, '{8'h40, 2'h1}};
		chk_cfgs();
		cw(2'h0, 8'h01, 2'h1);
		cw(2'h2, 8'h0c, 2'h0);
		chk_cfgs();
		@(posedge clock_in);
		stop_p <= 1'b1;
		wait_n(5);
		chk("trip", 1'b1, trip);
		chk("code", 8'h25, code);
		chk("gate", 1'b0, gate);
		// Stop released first, so the console pulse alone could clear
		@(posedge clock_in);
		stop_p <= 1'b0;
		wait_n(4);
		@(posedge clock_in);
		con_rst <= 1'b1;
		@(posedge clock_in);
		con_rst <= 1'b0;
		#1;
		chk("console reset", 1'b1, rst_act);
		wait_n(4);
		chk("trip kept", 1'b1, trip);
		chk("gate held", 1'b0, gate);
		pulse_reset_pin();
		chk("trip cleared", 1'b0, trip);
		chk("code cleared", 8'h00, code);
		chk("gate back", 1'b1, gate);
		@(posedge clock_in);
		open_w <= 1'b1;
		wait_n(5);
		chk("open trip", 1'b1, trip);
		@(posedge clock_in);
		open_w <= 1'b0;
		pulse_reset_pin();
		chk("trip cleared", 1'b0, trip);
		@(posedge clock_in);
		sw <= 1'b0;
		wait_n(5);
		exp_cfg[2].func = 8'hff;
		chk_cfgs();
		cw(2'h0, 8'h0c, 2'h1);
		exp_cfg[0] = exp_wr(8'h0c, 2'h1);
		chk_cfgs();
		wrap_up();
	end
endmodule // est_shutoff_tb
